// file: hdl/route_pkg.sv
// Notes on behaviour
// - Reset loads routing bits 0-4 from stored value
// - Run-time write overrides stored routing until reset
// - Routing register sits at offset E2h
// - Peripheral I/O enable clears on reset
// - Bit 7 enables peripheral mode only
// - Main flash: data needs bit 4, fetch bit 2
// - Secondary flash data strobes need bit 3
// - Secondary flash fetch strobes need bit 1
// - SRAM always data; fetch needs bit 0
// - Control block answers data cycles only
// - Secondary flash beats main flash on overlap
// - SRAM, control, peripheral beat any flash
// - Non-flash select ranges never overlap
// - Same-kind flash sector selects never overlap
// - Flash select never exceeds sector size
// - Registers at base plus offset; unused read zero
package route_pkg;

  localparam logic [7:0] ROUTING_OFFSET  = 8'hE2;
  localparam logic [7:0] ROUTING_MASK    = 8'h9F;
  localparam logic [4:0] NV_ROUTING_DFLT = 5'h0C;
  localparam int         BIT_SRAM_FETCH  = 0;
  localparam int         BIT_SEC_FETCH   = 1;
  localparam int         BIT_MAIN_FETCH  = 2;
  localparam int         BIT_SEC_DATA    = 3;
  localparam int         BIT_MAIN_DATA   = 4;
  localparam int         BIT_PERIPH_EN   = 7;
  localparam int         MAIN_SECTORS    = 8;
  localparam int         SEC_SECTORS     = 4;
  localparam int         PERIPH_SELECTS  = 8;

  typedef enum logic [2:0] {
    TGT_NONE   = 3'h0,
    TGT_MAIN   = 3'h1,
    TGT_SEC    = 3'h2,
    TGT_SRAM   = 3'h3,
    TGT_CTRL   = 3'h4,
    TGT_PERIPH = 3'h5
  } target_type;

endpackage

// file: hdl/route_if.sv
`timescale 1ns/1ps
// Core-side bus cycle as seen by the memory decode
interface route_if;
  import route_pkg::*;
  logic                      rd_strobe;
  logic                      wr_strobe;
  logic                      program_fetch_strobe;
  logic [7:0]                addr_low;
  logic [7:0]                wdata;
  logic [MAIN_SECTORS-1:0]   main_flash_sector_select;
  logic [SEC_SECTORS-1:0]    secondary_flash_sector_select;
  logic                      sram_select;
  logic                      ctrl_select;
  logic [PERIPH_SELECTS-1:0] peripheral_select;
  logic [7:0]                rdata;
  logic                      rdata_valid;

  modport device (
    input  rd_strobe, wr_strobe, program_fetch_strobe, addr_low, wdata,
    input  main_flash_sector_select, secondary_flash_sector_select,
    input  sram_select, ctrl_select, peripheral_select,
    output rdata, rdata_valid
  );
  modport core (
    output rd_strobe, wr_strobe, program_fetch_strobe, addr_low, wdata,
    output main_flash_sector_select, secondary_flash_sector_select,
    output sram_select, ctrl_select, peripheral_select,
    input  rdata, rdata_valid
  );
endinterface

// file: hdl/memory_space_routing_decode.sv
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module memory_space_routing_decode
  import route_pkg::*;
(
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  // Stored configuration
  input  wire logic [4:0]              nv_routing,
  // Core bus
  route_if.device                      bus,
  // Memory strobes
  output logic                         main_rd,
  output logic                         main_wr,
  output logic                         main_fetch,
  output logic                         sec_rd,
  output logic                         sec_wr,
  output logic                         sec_fetch,
  output logic                         sram_rd,
  output logic                         sram_wr,
  output logic                         sram_fetch,
  output logic                         ctrl_rd,
  output logic                         ctrl_wr,
  output logic                         periph_rd,
  output logic                         periph_wr,
  output logic [2:0]                   target,
  output logic                         peripheral_io_enable
);

  // ****************************************
  // Local state
  // ****************************************
  // Strobes are registered so every output leaves a flip-flop; costs one cycle
  typedef struct packed {
    logic       loaded;
    logic [7:0] routing;
    logic [7:0] rdata;
    logic       rvalid;
    logic       main_rd;
    logic       main_wr;
    logic       main_fetch;
    logic       sec_rd;
    logic       sec_wr;
    logic       sec_fetch;
    logic       sram_rd;
    logic       sram_wr;
    logic       sram_fetch;
    logic       ctrl_rd;
    logic       ctrl_wr;
    logic       periph_rd;
    logic       periph_wr;
    logic [2:0] tgt;
  } state_type;

  state_type  state_r, state_nxt;
  target_type winner;
  logic       data_cyc;
  logic       any_cyc;
  logic       main_hit;
  logic       sec_hit;
  logic       reg_wr_hit;
  logic       reg_rd_hit;
  logic       main_data_en;
  logic       main_fetch_en;
  logic       sec_data_en;
  logic       sec_fetch_en;
  logic       sram_fetch_en;

  always_comb begin
    // ****************************************
    // Decoded hits and routing enables
    // ****************************************
    data_cyc      = bus.rd_strobe | bus.wr_strobe;
    any_cyc       = data_cyc | bus.program_fetch_strobe;
    main_hit      = |bus.main_flash_sector_select;
    sec_hit       = |bus.secondary_flash_sector_select;
    reg_wr_hit    = bus.ctrl_select & bus.wr_strobe & (bus.addr_low == ROUTING_OFFSET);
    reg_rd_hit    = bus.ctrl_select & bus.rd_strobe;
    main_data_en  = state_r.routing[BIT_MAIN_DATA];
    main_fetch_en = state_r.routing[BIT_MAIN_FETCH];
    sec_data_en   = state_r.routing[BIT_SEC_DATA];
    sec_fetch_en  = state_r.routing[BIT_SEC_FETCH];
    sram_fetch_en = state_r.routing[BIT_SRAM_FETCH];
    state_nxt        = state_r;
    state_nxt.rvalid = 1'b0;
    state_nxt.rdata  = 8'h00;

    // ****************************************
    // Routing load after reset
    // ****************************************
    // Input is static; loading it one cycle after release keeps reset a pure constant
    if (!state_r.loaded) begin
      state_nxt.loaded       = 1'b1;
      state_nxt.routing[4:0] = nv_routing;
    end

    // ****************************************
    // Register access
    // ****************************************
    // A write in the loading cycle lands after the load, so the write wins
    if (reg_wr_hit) begin
      state_nxt.routing = bus.wdata & ROUTING_MASK;
      state_nxt.loaded  = 1'b1;
    end
    if (reg_rd_hit) begin
      state_nxt.rvalid = 1'b1;
      if (bus.addr_low == ROUTING_OFFSET) begin
        state_nxt.rdata = state_r.routing & ROUTING_MASK;
      end else begin
        state_nxt.rdata = 8'h00;
      end
    end

    // ****************************************
    // Priority and routing
    // ****************************************
    // Same-level selects must not overlap; the fixed order only avoids contention
    if (!any_cyc) begin
      winner = TGT_NONE;
    end else if (bus.sram_select) begin
      winner = TGT_SRAM;
    end else if (bus.ctrl_select) begin
      winner = TGT_CTRL;
    end else if (|bus.peripheral_select) begin
      winner = TGT_PERIPH;
    end else if (sec_hit) begin
      winner = TGT_SEC;
    end else if (main_hit) begin
      winner = TGT_MAIN;
    end else begin
      winner = TGT_NONE;
    end
    state_nxt.tgt        = winner;
    state_nxt.main_rd    = 1'b0;
    state_nxt.main_wr    = 1'b0;
    state_nxt.main_fetch = 1'b0;
    state_nxt.sec_rd     = 1'b0;
    state_nxt.sec_wr     = 1'b0;
    state_nxt.sec_fetch  = 1'b0;
    state_nxt.sram_rd    = 1'b0;
    state_nxt.sram_wr    = 1'b0;
    state_nxt.sram_fetch = 1'b0;
    state_nxt.ctrl_rd    = 1'b0;
    state_nxt.ctrl_wr    = 1'b0;
    state_nxt.periph_rd  = 1'b0;
    state_nxt.periph_wr  = 1'b0;
    case (winner)
      TGT_MAIN: begin
        state_nxt.main_rd    = bus.rd_strobe & main_data_en;
        state_nxt.main_wr    = bus.wr_strobe & main_data_en;
        state_nxt.main_fetch = bus.program_fetch_strobe & main_fetch_en;
      end
      TGT_SEC: begin
        state_nxt.sec_rd    = bus.rd_strobe & sec_data_en;
        state_nxt.sec_wr    = bus.wr_strobe & sec_data_en;
        state_nxt.sec_fetch = bus.program_fetch_strobe & sec_fetch_en;
      end
      TGT_SRAM: begin
        state_nxt.sram_rd    = bus.rd_strobe;
        state_nxt.sram_wr    = bus.wr_strobe;
        state_nxt.sram_fetch = bus.program_fetch_strobe & sram_fetch_en;
      end
      TGT_CTRL: begin
        state_nxt.ctrl_rd = bus.rd_strobe;
        state_nxt.ctrl_wr = bus.wr_strobe;
      end
      TGT_PERIPH: begin
        state_nxt.periph_rd = bus.rd_strobe;
        state_nxt.periph_wr = bus.wr_strobe;
      end
      default: begin
        state_nxt.tgt = TGT_NONE;
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  // Reset clears everything, the peripheral enable included
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign main_rd    = state_r.main_rd;
  assign main_wr    = state_r.main_wr;
  assign main_fetch = state_r.main_fetch;
  assign sec_rd     = state_r.sec_rd;
  assign sec_wr     = state_r.sec_wr;
  assign sec_fetch  = state_r.sec_fetch;
  assign sram_rd    = state_r.sram_rd;
  assign sram_wr    = state_r.sram_wr;
  assign sram_fetch = state_r.sram_fetch;
  assign ctrl_rd    = state_r.ctrl_rd;
  assign ctrl_wr    = state_r.ctrl_wr;
  assign periph_rd  = state_r.periph_rd;
  assign periph_wr  = state_r.periph_wr;
  assign target     = state_r.tgt;
  assign peripheral_io_enable = state_r.routing[BIT_PERIPH_EN];
  assign bus.rdata       = state_r.rdata;
  assign bus.rdata_valid = state_r.rvalid;

endmodule // memory_space_routing_decode

// file: hdl/core_cycle_driver.sv
`timescale 1ns/1ps
module core_cycle_driver
  import route_pkg::*;
(
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  // User command port
  input  wire logic                      cmd_rd,
  input  wire logic                      cmd_wr,
  input  wire logic                      cmd_fetch,
  input  wire logic [7:0]                cmd_addr,
  input  wire logic [7:0]                cmd_wdata,
  input  wire logic [MAIN_SECTORS-1:0]   cmd_main_sel,
  input  wire logic [SEC_SECTORS-1:0]    cmd_sec_sel,
  input  wire logic                      cmd_sram_sel,
  input  wire logic                      cmd_ctrl_sel,
  input  wire logic [PERIPH_SELECTS-1:0] cmd_periph_sel,
  output logic [7:0]                     rsp_data,
  output logic                           rsp_valid,
  // Device side
  route_if.core                          bus
);

  typedef struct packed {
    logic                      rd;
    logic                      wr;
    logic                      fetch;
    logic [7:0]                addr;
    logic [7:0]                wdata;
    logic [MAIN_SECTORS-1:0]   msel;
    logic [SEC_SECTORS-1:0]    ssel;
    logic                      sram;
    logic                      ctrl;
    logic [PERIPH_SELECTS-1:0] psel;
    logic [7:0]                rdata;
    logic                      rvalid;
  } drv_type;

  drv_type drv_r, drv_nxt;

  // Select ranges are the caller's to keep apart; overlaps pass through and the decode's fixed order picks one
  always_comb begin
    drv_nxt        = drv_r;
    drv_nxt.rd     = cmd_rd;
    drv_nxt.wr     = cmd_wr & ~cmd_rd;
    drv_nxt.fetch  = cmd_fetch;
    drv_nxt.addr   = cmd_addr;
    drv_nxt.wdata  = cmd_wdata;
    drv_nxt.msel   = cmd_main_sel;
    drv_nxt.ssel   = cmd_sec_sel;
    drv_nxt.sram   = cmd_sram_sel;
    drv_nxt.ctrl   = cmd_ctrl_sel;
    drv_nxt.psel   = cmd_periph_sel;
    drv_nxt.rdata  = bus.rdata;
    drv_nxt.rvalid = bus.rdata_valid;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      drv_r <= '0;
    end else begin
      drv_r <= drv_nxt;
    end
  end

  assign bus.rd_strobe                     = drv_r.rd;
  assign bus.wr_strobe                     = drv_r.wr;
  assign bus.program_fetch_strobe          = drv_r.fetch;
  assign bus.addr_low                      = drv_r.addr;
  assign bus.wdata                         = drv_r.wdata;
  assign bus.main_flash_sector_select      = drv_r.msel;
  assign bus.secondary_flash_sector_select = drv_r.ssel;
  assign bus.sram_select                   = drv_r.sram;
  assign bus.ctrl_select                   = drv_r.ctrl;
  assign bus.peripheral_select             = drv_r.psel;
  assign rsp_data                          = drv_r.rdata;
  assign rsp_valid                         = drv_r.rvalid;

endmodule // core_cycle_driver

// file: test/routing_chk.sv
`timescale 1ns/1ps
module routing_chk
  import route_pkg::*;
(
  // Clock and reset
  input wire logic                   mclk,
  input wire logic                   rst_n,
  // Core bus
  input wire logic                   rd_strobe,
  input wire logic                   wr_strobe,
  input wire logic                   program_fetch_strobe,
  input wire logic [7:0]             addr_low,
  input wire logic [7:0]             wdata,
  input wire logic [7:0]             rdata,
  input wire logic                   sram_select,
  input wire logic                   ctrl_select,
  input wire logic                   rdata_valid,
  input wire logic [SEC_SECTORS-1:0] secondary_flash_sector_select,
  // Decoded strobes
  input wire logic                   main_rd,
  input wire logic                   sec_rd,
  input wire logic                   sram_rd,
  input wire logic                   ctrl_rd,
  input wire logic                   ctrl_wr,
  input wire logic                   peripheral_io_enable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ****************
  // Checks
  // ****************
  chk_ctrl_no_fetch: assert property (
    program_fetch_strobe && !rd_strobe && !wr_strobe |=> !ctrl_rd && !ctrl_wr)
    else $error("control block answered a fetch");
  chk_sram_data: assert property (rd_strobe && sram_select |=> sram_rd)
    else $error("sram missed a data read");
  chk_sec_over_main: assert property (
    rd_strobe && |secondary_flash_sector_select && !sram_select && !ctrl_select |=> !main_rd)
    else $error("main flash beat secondary flash");
  chk_nonflash_wins: assert property (
    rd_strobe && sram_select |=> !main_rd && !sec_rd)
    else $error("flash beat sram");
  chk_read_answer: assert property (
    rdata_valid == $past(rd_strobe && ctrl_select))
    else $error("read answer misplaced");
  chk_unused_zero: assert property (
    rdata_valid && $past(addr_low) != ROUTING_OFFSET |-> rdata == 8'h00)
    else $error("unused offset read nonzero");
  chk_idle_zero: assert property (!rdata_valid |-> rdata == 8'h00)
    else $error("read data outside answer");
  chk_spare_bits: assert property (rdata_valid |-> rdata[6:5] == 2'b00)
    else $error("spare bits read nonzero");
  chk_pio_write: assert property (
    ctrl_select && wr_strobe && addr_low == ROUTING_OFFSET
    |=> peripheral_io_enable == $past(wdata[7]))
    else $error("peripheral enable not written");
  cover property (rdata_valid);
  cover property (rd_strobe && sram_select && |secondary_flash_sector_select);
  cover property (ctrl_select && wr_strobe && addr_low == ROUTING_OFFSET);
endmodule // routing_chk

// file: test/memory_space_routing_decode_bench.sv
`timescale 1ns/1ps
module memory_space_routing_decode_bench;
  import route_pkg::*;
  logic        mclk = 1'b0, rst_n = 1'b0, c_rd = 1'b0, c_wr = 1'b0, c_fetch = 1'b0;
  logic        c_sram = 1'b0, c_ctrl = 1'b0, rsp_valid, pio;
  logic [4:0]  nv_routing = NV_ROUTING_DFLT;
  logic [7:0]  c_addr = 8'h00, c_wdata = 8'h00, c_main = 8'h00, c_periph = 8'h00, rsp_data;
  logic [3:0]  c_sec = 4'h0;
  wire  [12:0] strb;
  logic [2:0]  target;
  int          err_count = 0, compares = 0, cyc = 0;
  route_if bus();
  always #10 mclk = ~mclk;
  core_cycle_driver i_core_cycle_driver (.mclk(mclk), .rst_n(rst_n), .cmd_rd(c_rd),
    .cmd_wr(c_wr), .cmd_fetch(c_fetch), .cmd_addr(c_addr), .cmd_wdata(c_wdata),
    .cmd_main_sel(c_main), .cmd_sec_sel(c_sec), .cmd_sram_sel(c_sram), .cmd_ctrl_sel(c_ctrl),
    .cmd_periph_sel(c_periph), .rsp_data(rsp_data), .rsp_valid(rsp_valid), .bus(bus));
  memory_space_routing_decode i_memory_space_routing_decode (.mclk(mclk), .rst_n(rst_n),
    .nv_routing(nv_routing), .bus(bus), .main_rd(strb[12]), .main_wr(strb[11]),
    .main_fetch(strb[10]), .sec_rd(strb[9]), .sec_wr(strb[8]), .sec_fetch(strb[7]),
    .sram_rd(strb[6]), .sram_wr(strb[5]), .sram_fetch(strb[4]), .ctrl_rd(strb[3]),
    .ctrl_wr(strb[2]), .periph_rd(strb[1]), .periph_wr(strb[0]), .target(target),
    .peripheral_io_enable(pio));
  routing_chk i_routing_chk (.mclk(mclk), .rst_n(rst_n), .rd_strobe(bus.rd_strobe),
    .wr_strobe(bus.wr_strobe), .program_fetch_strobe(bus.program_fetch_strobe),
    .addr_low(bus.addr_low), .wdata(bus.wdata), .rdata(bus.rdata),
    .sram_select(bus.sram_select), .ctrl_select(bus.ctrl_select),
    .rdata_valid(bus.rdata_valid),
    .secondary_flash_sector_select(bus.secondary_flash_sector_select),
    .main_rd(strb[12]), .sec_rd(strb[9]), .sram_rd(strb[6]), .ctrl_rd(strb[3]),
    .ctrl_wr(strb[2]), .peripheral_io_enable(pio));
  // ****************
  // Tasks
  // ****************
  task automatic finish_test;
    if (err_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk13(input logic [12:0] got, input logic [12:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t strobes %h expected %h", $time, got, exp);
    end
  endtask
  // Kind is {rd, wr, fetch}; sel is {sram, ctrl, periph0}; strobes land two edges later
  task automatic op(input logic [2:0] k, input logic [7:0] a, input logic [7:0] d,
                    input logic [7:0] m, input logic [3:0] s, input logic [2:0] sel);
    @(posedge mclk);
    {c_rd, c_wr, c_fetch} <= k;
    {c_addr, c_wdata, c_main, c_sec} <= {a, d, m, s};
    {c_sram, c_ctrl, c_periph} <= {sel[2:1], 7'h00, sel[0]};
    @(posedge mclk);
    {c_rd, c_wr, c_fetch, c_sram, c_ctrl} <= 5'h00;
    {c_main, c_sec, c_periph} <= 20'h00000;
    @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    int i;
    op(3'b100, a, 8'h00, 8'h00, 4'h0, 3'b010);
    for (i = 0; i < 4 && rsp_valid !== 1'b1; i++) @(negedge mclk);
    chk8({7'h00, rsp_valid}, 8'h01);
    chk8(rsp_data, exp);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    op(3'b010, a, d, 8'h00, 4'h0, 3'b010);
  endtask
  // Op 0 rd, 1 wr, 2 fetch; tgt 0 main, 1 sec, 2 sram, 3 ctrl
  function automatic logic [12:0] exp_strb(int o, int tgt, logic [7:0] v);
    logic en;
    exp_strb = 13'h0000;
    case (tgt * 3 + o)
      0, 1: en = v[4];
      2: en = v[2];
      3, 4: en = v[3];
      5: en = v[1];
      8: en = v[0];
      6, 7, 9, 10: en = 1'b1;
      default: en = 1'b0;
    endcase
    exp_strb[12 - (tgt * 3 + o)] = en;
  endfunction
  task automatic t_reset_value;
    rd_reg(ROUTING_OFFSET, {3'b000, NV_ROUTING_DFLT});
    chk8({7'h00, pio}, 8'h00);
    rd_reg(8'h10, 8'h00);
  endtask
  task automatic t_routing;
    for (int v = 0; v < 32; v++) begin
      wr_reg(ROUTING_OFFSET, 8'(v) | 8'h60);
      rd_reg(ROUTING_OFFSET, 8'(v));
      for (int t = 0; t < 4; t++) begin
        for (int o = 0; o < 3; o++) begin
          op(3'b100 >> o, (t == 3) ? 8'h10 : 8'h00, 8'h5A, (t == 0) ? 8'h01 : 8'h00,
             (t == 1) ? 4'h1 : 4'h0, {t == 2, t == 3, 1'b0});
          chk13(strb, exp_strb(o, t, 8'(v)));
        end
      end
    end
  endtask
  task automatic t_prio;
    wr_reg(ROUTING_OFFSET, 8'h1F);
    op(3'b100, 8'h00, 8'h00, 8'h01, 4'h0, 3'b000);
    chk13(strb, 13'h1000);
    chk8({5'h00, target}, 8'h01);
    op(3'b000, 8'h00, 8'h00, 8'h01, 4'h1, 3'b100);
    chk13(strb, 13'h0000);
    chk8({5'h00, target}, 8'h00);
    op(3'b010, 8'h00, 8'h00, 8'h01, 4'h0, 3'b001);
    chk13(strb, 13'h0001);
    chk8({5'h00, target}, 8'h05);
    op(3'b100, 8'h00, 8'h00, 8'h80, 4'h8, 3'b000);
    chk13(strb, 13'h0200);
    chk8({5'h00, target}, 8'h02);
    op(3'b100, 8'h00, 8'h00, 8'h01, 4'h1, 3'b100);
    chk13(strb, 13'h0040);
    chk8({5'h00, target}, 8'h03);
    op(3'b010, 8'h10, 8'hFF, 8'h01, 4'h0, 3'b010);
    chk13(strb, 13'h0004);
    chk8({5'h00, target}, 8'h04);
    op(3'b100, 8'h00, 8'h00, 8'h00, 4'h2, 3'b001);
    chk13(strb, 13'h0002);
    chk8({5'h00, target}, 8'h05);
    op(3'b001, 8'hE2, 8'h00, 8'h01, 4'h0, 3'b010);
    chk13(strb, 13'h0000);
    rd_reg(ROUTING_OFFSET, 8'h1F);
  endtask
  task automatic t_pio_reset;
    wr_reg(ROUTING_OFFSET, 8'h83);
    chk8({7'h00, pio}, 8'h01);
    rd_reg(ROUTING_OFFSET, 8'h83);
    op(3'b001, 8'h00, 8'h00, 8'h00, 4'h0, 3'b100);
    chk13(strb, 13'h0010);
    @(posedge mclk);
    {nv_routing, rst_n} <= {5'h13, 1'b0};
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk8({7'h00, pio}, 8'h00);
    rd_reg(ROUTING_OFFSET, 8'h13);
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      finish_test;
    end
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    t_reset_value;
    t_routing;
    t_prio;
    t_pio_reset;
    finish_test;
  end
endmodule // memory_space_routing_decode_bench
